// ### include/omx_consts.svh
// timing-free constants for the or/move/option execution block
`ifndef OMX_CONSTS_SVH
`define OMX_CONSTS_SVH
`define OMX_OP_NOP 12'h000
`define OMX_OP_OPTION 12'h002
`define OMX_TOP6_STORE 6'h00
`define OMX_TOP6_OR_FILE 6'h04
`define OMX_TOP6_MOVE_FILE 6'h08
`define OMX_TOP4_LOAD_LIT 4'hC
`define OMX_TOP4_OR_LIT 4'hD
`define OMX_STORE_BIT 5
`define OMX_DEST_BIT 5
`define OMX_ACC_RESET 8'h00
`define OMX_OPT_RESET 8'hFF
`define OMX_ZERO_RESET 1'h0
`endif

// ### include/omx_pkg.sv
// types shared by the or/move/option execution block
package omx_pkg;
	typedef enum logic [2:0] {
		OMX_NONE = 3'h0,
		OMX_OR_LIT = 3'h1,
		OMX_OR_FILE = 3'h3,
		OMX_MOVE_FILE = 3'h2,
		OMX_LOAD_LIT = 3'h6,
		OMX_STORE = 3'h7,
		OMX_OPTION = 3'h5,
		OMX_NOP = 3'h4
	} omx_op_type;
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] option;
		logic zero;
		logic file_we;
		logic [4:0] file_addr;
		logic [7:0] file_wdata;
		logic done;
		logic illegal;
	} omx_state_type;
endpackage : omx_pkg

// ### include/omx_dec_if.sv
// decoded instruction fields passed from the decoder to the executor
`timescale 1ns/10ps
`default_nettype none
interface omx_dec_if;
	import omx_pkg::*;
	omx_op_type op;
	logic [7:0] literal;
	logic [4:0] faddr;
	logic dest_file;
	modport dec (output op, output literal, output faddr, output dest_file);
	modport exe (input op, input literal, input faddr, input dest_file);
endinterface : omx_dec_if
`default_nettype wire

// ### logic/omx_decoder.sv
// instruction word decoder for the or/move/option subset
`timescale 1ns/10ps
`default_nettype none
`include "omx_consts.svh"
module omx_decoder (
	input wire logic [11:0] instr,
	omx_dec_if.dec dec
);
	import omx_pkg::*;
	function automatic omx_op_type classify(input logic [11:0] w);
		omx_op_type r;
		r = OMX_NONE;
		if (w == `OMX_OP_NOP) begin
			r = OMX_NOP;
		end else if (w == `OMX_OP_OPTION) begin
			r = OMX_OPTION;
		end else if (w[11:6] == `OMX_TOP6_STORE && w[`OMX_STORE_BIT]) begin
			r = OMX_STORE;
		end else if (w[11:6] == `OMX_TOP6_OR_FILE) begin
			r = OMX_OR_FILE;
		end else if (w[11:6] == `OMX_TOP6_MOVE_FILE) begin
			r = OMX_MOVE_FILE;
		end else if (w[11:8] == `OMX_TOP4_LOAD_LIT) begin
			r = OMX_LOAD_LIT;
		end else if (w[11:8] == `OMX_TOP4_OR_LIT) begin
			r = OMX_OR_LIT;
		end
		return r;
	endfunction : classify
	assign dec.op = classify(instr);
	assign dec.literal = instr[7:0];
	assign dec.faddr = instr[4:0];
	assign dec.dest_file = instr[`OMX_DEST_BIT];
endmodule : omx_decoder
`default_nettype wire

// ### logic/omx_exec.sv
// single-cycle executor for or, move, load-literal, store, option and no-op
`timescale 1ns/10ps
`default_nettype none
`include "omx_consts.svh"
// What this block does
// - or literal into accumulator, set zero
// - or accumulator with file, set zero
// - destination bit: 0 accumulator, 1 file
// - move file register to chosen destination
// - move updates zero from moved value
// - store accumulator to file, flags kept
// - load option from accumulator, flags kept
// - every instruction completes in one cycle
module omx_exec (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	output logic [4:0] file_raddr,
	input wire logic [7:0] file_rdata,
	output logic file_we,
	output logic [4:0] file_waddr,
	output logic [7:0] file_wdata,
	output logic [7:0] acc,
	output logic [7:0] option_reg,
	output logic zero_flag,
	output logic instr_done,
	output logic instr_illegal
);
	import omx_pkg::*;
	omx_dec_if dif ();
	omx_state_type st_r;
	omx_state_type st_nxt;
	logic [7:0] result;
	omx_decoder u_dec (
		.instr(instr),
		.dec(dif)
	);
	// file read is combinational so the whole instruction fits one cycle
	assign file_raddr = dif.faddr;
	always_comb begin
		st_nxt = st_r;
		st_nxt.file_we = 1'b0;
		st_nxt.done = 1'b0;
		st_nxt.illegal = 1'b0;
		result = 8'h00;
		if (instr_valid) begin
			st_nxt.done = 1'b1;
			case (dif.op)
			OMX_OR_LIT: begin
				result = st_r.acc | dif.literal;
				st_nxt.acc = result;
				st_nxt.zero = (result == 8'h00);
			end
			OMX_OR_FILE, OMX_MOVE_FILE: begin
				result = (dif.op == OMX_OR_FILE) ? (st_r.acc | file_rdata) : file_rdata;
				st_nxt.zero = (result == 8'h00);
				if (dif.dest_file) begin
					st_nxt.file_we = 1'b1;
					st_nxt.file_addr = dif.faddr;
					st_nxt.file_wdata = result;
				end else begin
					st_nxt.acc = result;
				end
			end
			OMX_LOAD_LIT: begin
				st_nxt.acc = dif.literal;
			end
			OMX_STORE: begin
				st_nxt.file_we = 1'b1;
				st_nxt.file_addr = dif.faddr;
				st_nxt.file_wdata = st_r.acc;
			end
			OMX_OPTION: begin
				st_nxt.option = st_r.acc;
			end
			OMX_NOP: begin
				st_nxt.done = 1'b1;
			end
			default: begin
				st_nxt.illegal = 1'b1;
			end
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_r <= '{acc: `OMX_ACC_RESET, option: `OMX_OPT_RESET, zero: `OMX_ZERO_RESET,
				file_we: 1'b0, file_addr: 5'h00, file_wdata: 8'h00, done: 1'b0,
				illegal: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign file_we = st_r.file_we;
	assign file_waddr = st_r.file_addr;
	assign file_wdata = st_r.file_wdata;
	assign acc = st_r.acc;
	assign option_reg = st_r.option;
	assign zero_flag = st_r.zero;
	assign instr_done = st_r.done;
	assign instr_illegal = st_r.illegal;
endmodule : omx_exec
`default_nettype wire

// ### tb/omx_file_mem.sv
// file register memory answering the executor
`timescale 1ns/10ps
`default_nettype none
module omx_file_mem (
	input wire logic clk_sys,
	input wire logic [4:0] file_raddr,
	output logic [7:0] file_rdata,
	input wire logic file_we,
	input wire logic [4:0] file_waddr,
	input wire logic [7:0] file_wdata
);
	logic [7:0] mem [32] = '{default: 8'h00};
	// forward a pending write so a back-to-back read sees it
	assign file_rdata = file_we && file_waddr == file_raddr ? file_wdata : mem[file_raddr];
	always @(posedge clk_sys) if (file_we) mem[file_waddr] <= file_wdata;
endmodule : omx_file_mem
`default_nettype wire

// ### tb/omx_exec_assertions.sv
// port checks for the executor
`timescale 1ns/10ps
`default_nettype none
module omx_exec_assertions (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	input wire logic [7:0] file_rdata,
	input wire logic file_we,
	input wire logic [7:0] file_wdata,
	input wire logic [7:0] acc,
	input wire logic [7:0] option_reg,
	input wire logic zero_flag,
	input wire logic instr_done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire logic v = instr_valid;
	wire logic [5:0] t = instr[11:6];
	chk_one_cycle: assert property (v |=> instr_done) else $error("no done");
	chk_or_lit: assert property (v && t[5:2] == 4'hD |=>
		acc == ($past(acc) | $past(instr[7:0])) && zero_flag == (acc == 8'h00)) else $error("or");
	chk_load_lit: assert property (v && t[5:2] == 4'hC |=>
		acc == $past(instr[7:0]) && $stable(zero_flag)) else $error("load");
	chk_dest_sel: assert property (v && (t == 6'h04 || t == 6'h08) |=>
		file_we == $past(instr[5])) else $error("dest");
	chk_move_zero: assert property (v && t == 6'h08 |=>
		zero_flag == ($past(file_rdata) == 8'h00)) else $error("move");
	chk_store_acc: assert property (v && instr[11:5] == 7'h01 |=>
		file_we && file_wdata == $past(acc) && $stable(zero_flag)) else $error("store");
	chk_option_load: assert property (v && instr == 12'h002 |=>
		option_reg == $past(acc) && $stable(zero_flag)) else $error("option");
	chk_nop_idle: assert property (v && instr == 12'h000 |=>
		!file_we && $stable(acc)) else $error("nop");
endmodule : omx_exec_assertions
bind omx_exec omx_exec_assertions i_chk (.*);
`default_nettype wire

// ### tb/omx_exec_tb.sv
// random and corner tests of the executor
`timescale 1ns/10ps
`default_nettype none
module omx_exec_tb;
	logic clk_sys = 0, nrst = 0, instr_valid = 0, file_we, zero_flag, instr_done, instr_illegal;
	logic [4:0] file_raddr, file_waddr;
	logic [7:0] file_rdata, file_wdata, acc, option_reg, a_x = 8'h00, o_x = 8'hFF, d_x, r;
	logic [7:0] m [32] = '{default: 8'h00};
	logic [11:0] instr = 12'h000;
	logic z_x = 0, w_x, ill, g, s;
	int miscompares = 0, n_checks = 0;
	const logic [11:0] cw [8] = '{12'hC9A, 12'hD35, 12'hC00, 12'hD00, 12'h023, 12'h223, 12'h002, 12'h000};
	always #5 clk_sys = ~clk_sys;
	omx_exec i_dut (.*);
	omx_file_mem i_mem (.*);
	task automatic end_sim;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	task automatic run(input logic [11:0] x);
		instr = x;
		instr_valid = 1;
		g = x[11:10] == 2'h0 && x[7:6] == 2'h0 && ^x[9:8];
		s = x[11:5] == 7'h01;
		ill = !(g || s || x[11:9] == 3'h6 || x == 12'h000 || x == 12'h002);
		w_x = s || g && x[5];
		r = x[9] ? m[x[4:0]] : a_x | m[x[4:0]];
		d_x = s ? a_x : r;
		if (w_x) m[x[4:0]] = d_x;
		if (g) z_x = r == 8'h00;
		if (g && !x[5]) a_x = r;
		if (x[11:8] == 4'hD) z_x = (a_x | x[7:0]) == 8'h00;
		if (x[11:9] == 3'h6) a_x = x[8] ? a_x | x[7:0] : x[7:0];
		if (x == 12'h002) o_x = a_x;
		@(negedge clk_sys);
		n_checks++;
		if ({acc, option_reg, zero_flag, file_we, instr_done, instr_illegal} !==
			{a_x, o_x, z_x, w_x, 1'b1, ill} || w_x && {file_waddr, file_wdata} !== {x[4:0], d_x}) begin
			miscompares++;
			$display("CHECK FAILED %0t word %h", $time, x);
		end
	endtask : run
	initial begin
		void'($urandom(52311));
		repeat (6) @(negedge clk_sys);
		nrst = 1;
		foreach (cw[i]) run(cw[i]);
		$display("corner test done");
		for (int i = 0; i < 600; i++) run(12'($urandom) & ($urandom % 2 ? 12'hFFF : 12'h33F));
		$display("random test done");
		end_sim;
	end
	initial begin
		#20000;
		miscompares++;
		end_sim;
	end
endmodule : omx_exec_tb
`default_nettype wire
